// ==== src/nco_top.sv ====
// numerically controlled oscillator: serial frequency load, accumulator, sine lookup
`timescale 1ns/1ps
module nco_top #(
    parameter int FREQ_W = nco_pkg::NCO_FREQ_W,
    parameter int SINE_W = nco_pkg::NCO_SINE_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic shift_clk,
    input wire logic shift_enable_n,
    input wire logic shift_msb_first,
    input wire logic serial_freq_in,
    input wire logic sel_low_word,
    input wire logic transfer_strobe_n,
    input wire logic load_strobe_n,
    input wire logic accum_enable_n,
    input wire logic [1:0] phase_mod_in,
    output logic [SINE_W-1:0] sine_out,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int PW = nco_pkg::NCO_PHASE_W;
    localparam int DEPTH = nco_pkg::NCO_LOAD_DELAY;

    ////////////////////////////////////////////////////////////////////////////
    // frequency shift register

    logic [2*FREQ_W-1:0] freq_reg;
    logic shift_clk_prev;
    logic shift_rise;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            shift_clk_prev <= 1'b0;
        else
            shift_clk_prev <= shift_clk;
    end

    assign shift_rise = shift_clk && !shift_clk_prev;

    // shifting does not wait for the pipeline: a stalled sink must not drop serial bits
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            freq_reg <= nco_pkg::NCO_SHIFT_RST;
        else if (shift_rise && !shift_enable_n)
        begin
            if (shift_msb_first)
                freq_reg <= {freq_reg[2*FREQ_W-2:0], serial_freq_in};
            else
                freq_reg <= {serial_freq_in, freq_reg[2*FREQ_W-1:1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control pipeline; every stage advances only when the buffer can take a word

    logic adv;
    nco_pkg::nco_ctrl_type ctl_in;
    nco_pkg::nco_ctrl_type ctl_pipe [0:DEPTH-1];
    nco_pkg::nco_ctrl_type ctl_4;
    logic load_5_n;

    assign ctl_in = '{transfer_strobe_n_n: transfer_strobe_n, load_n: load_strobe_n, acc_en_n: accum_enable_n,
                      sel_low: sel_low_word, phase: nco_pkg::nco_pm_type'(phase_mod_in)};

    generate
        for (genvar g = 0; g < DEPTH; g++)
        begin : g_ctl
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    ctl_pipe[g] <= nco_pkg::NCO_CTRL_RST;
                else if (adv)
                    ctl_pipe[g] <= (g == 0) ? ctl_in : ctl_pipe[(g == 0) ? 0 : g-1];
            end
        end
    endgenerate

    // sampled at edge k, acted upon at edge k+4 (k+5 for the load strobe)
    assign ctl_4 = ctl_pipe[nco_pkg::NCO_TRANSFER_STROBE_N_DELAY-1];
    assign load_5_n = ctl_pipe[nco_pkg::NCO_LOAD_DELAY-1].load_n;

    ////////////////////////////////////////////////////////////////////////////
    // input register and phase accumulator

    logic [FREQ_W-1:0] mux_word;
    logic [FREQ_W-1:0] in_reg;
    logic [FREQ_W-1:0] phase_acc;
    logic [FREQ_W-1:0] next_phase_acc;

    // select travels with the strobe so the chosen word matches the transfer
    assign mux_word = ctl_4.sel_low ? freq_reg[FREQ_W-1:0] : freq_reg[2*FREQ_W-1:FREQ_W];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            in_reg <= nco_pkg::NCO_FREQ_RST;
        else if (adv && !ctl_4.transfer_strobe_n_n)
            in_reg <= mux_word;
    end

    // modulo wrap gives f_out = word * f_clk / 2^32
    assign next_phase_acc = (load_5_n ? phase_acc : nco_pkg::NCO_FREQ_RST) + in_reg;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            phase_acc <= nco_pkg::NCO_FREQ_RST;
        else if (adv && !ctl_4.acc_en_n)
            phase_acc <= next_phase_acc;
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase offset adder and sine lookup

    logic [PW-1:0] phase_addr;
    logic [10:0] quarter [0:nco_pkg::NCO_QTR_ENTRIES-1];
    logic [11:0] qidx;
    logic [SINE_W-1:0] rom_data;
    logic rom_valid;
    logic buf_ready;

    // 0 is 0 degrees, 1000 hex is 180 degrees
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            phase_addr <= '0;
        else if (adv)
            phase_addr <= phase_acc[FREQ_W-1:FREQ_W-PW] + nco_pkg::nco_phase_ofs(ctl_4.phase);
    end

    generate
        for (genvar i = 0; i < nco_pkg::NCO_QTR_ENTRIES; i++)
        begin : g_rom
            assign quarter[i] = 11'(nco_pkg::nco_sin_q(i));
        end
    endgenerate

    // quarter table mirrored: index runs 0..2048 so both ends of a quadrant exist
    assign qidx = phase_addr[11] ? 12'(13'h1000 - {1'b0, phase_addr[11:0]}) : phase_addr[11:0];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rom_data <= nco_pkg::NCO_SINE_RST;
        else if (adv)
        begin
            if (phase_addr[PW-1])
                rom_data <= nco_pkg::NCO_MID_LEVEL - {1'b0, quarter[qidx]};
            else
                rom_data <= nco_pkg::NCO_MID_LEVEL + {1'b0, quarter[qidx]};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rom_valid <= 1'b0;
        else if (adv)
            rom_valid <= 1'b1;
    end

    // the whole datapath stalls with the buffer, so no sample is skipped
    assign adv = buf_ready;

    nco_out_buf #(
        .W(SINE_W)
    ) u_out_buf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(rom_valid),
        .in_data(rom_data),
        .in_ready(buf_ready),
        .out_valid(out_valid),
        .out_data(sine_out),
        .out_ready(out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_shift_msb;
        @(posedge clk_sys) disable iff (!rstn)
        shift_rise && !shift_enable_n && shift_msb_first |=>
            freq_reg[0] == $past(serial_freq_in) && freq_reg[63:1] == $past(freq_reg[62:0]);
    endproperty
    a_shift_msb: assert property (p_shift_msb) else $error("msb-first shift wrong");

    property p_shift_lsb;
        @(posedge clk_sys) disable iff (!rstn)
        shift_rise && !shift_enable_n && !shift_msb_first |=>
            freq_reg[63] == $past(serial_freq_in) && freq_reg[62:0] == $past(freq_reg[63:1]);
    endproperty
    a_shift_lsb: assert property (p_shift_lsb) else $error("lsb-first shift wrong");

    property p_shift_hold;
        @(posedge clk_sys) disable iff (!rstn)
        !(shift_rise && !shift_enable_n) |=> $stable(freq_reg);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift register moved without enable");

    property p_transfer_strobe_n_delay;
        @(posedge clk_sys) disable iff (!rstn)
        (adv && !transfer_strobe_n && sel_low_word) ##1 adv[*4] |=>
            in_reg == $past(freq_reg[31:0]);
    endproperty
    a_transfer_strobe_n_delay: assert property (p_transfer_strobe_n_delay) else $error("transfer not taken four clocks later");

    property p_freeze;
        @(posedge clk_sys) disable iff (!rstn)
        (adv && accum_enable_n) ##1 adv[*4] |=> $stable(phase_acc);
    endproperty
    a_freeze: assert property (p_freeze) else $error("accumulator stepped while disabled");

    property p_step;
        @(posedge clk_sys) disable iff (!rstn)
        adv && !ctl_4.acc_en_n && load_5_n |=> phase_acc == 32'($past(phase_acc) + $past(in_reg));
    endproperty
    a_step: assert property (p_step) else $error("accumulator step wrong");

    property p_load;
        @(posedge clk_sys) disable iff (!rstn)
        (adv && !load_strobe_n) ##1 adv[*5] ##0 !ctl_4.acc_en_n |=> phase_acc == $past(in_reg);
    endproperty
    a_load: assert property (p_load) else $error("load did not zero feedback five clocks later");

    property p_phase_90;
        @(posedge clk_sys) disable iff (!rstn)
        adv && ctl_4.phase == nco_pkg::NCO_PM_90 |=>
            phase_addr == 13'($past(phase_acc[31:19]) + 13'h0800);
    endproperty
    a_phase_90: assert property (p_phase_90) else $error("90 degree offset wrong");

    property p_range;
        @(posedge clk_sys) disable iff (!rstn)
        rom_valid |-> rom_data >= nco_pkg::NCO_MIN_LEVEL;
    endproperty
    a_range: assert property (p_range) else $error("sine sample out of range");

    property p_transfer_strobe_n_high;
        @(posedge clk_sys) disable iff (!rstn)
        (adv && !transfer_strobe_n && !sel_low_word) ##1 adv[*4] |=>
            in_reg == $past(freq_reg[63:32]);
    endproperty
    a_transfer_strobe_n_high: assert property (p_transfer_strobe_n_high) else $error("upper word not taken on low select");

    property p_in_hold;
        @(posedge clk_sys) disable iff (!rstn)
        !adv || ctl_4.transfer_strobe_n_n |=> $stable(in_reg);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("input register moved without transfer");

    property p_acc_hold;
        @(posedge clk_sys) disable iff (!rstn)
        !adv || ctl_4.acc_en_n |=> $stable(phase_acc);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved while held");

    property p_load_zero;
        @(posedge clk_sys) disable iff (!rstn)
        adv && !ctl_4.acc_en_n && !load_5_n |=> phase_acc == $past(in_reg);
    endproperty
    a_load_zero: assert property (p_load_zero) else $error("load kept accumulator feedback");

    property p_phase_180;
        @(posedge clk_sys) disable iff (!rstn)
        adv && ctl_4.phase == nco_pkg::NCO_PM_180 |=>
            phase_addr == 13'($past(phase_acc[31:19]) + 13'h1000);
    endproperty
    a_phase_180: assert property (p_phase_180) else $error("180 degree offset wrong");

    property p_phase_270;
        @(posedge clk_sys) disable iff (!rstn)
        adv && ctl_4.phase == nco_pkg::NCO_PM_270 |=>
            phase_addr == 13'($past(phase_acc[31:19]) + 13'h1800);
    endproperty
    a_phase_270: assert property (p_phase_270) else $error("270 degree offset wrong");

    property p_phase_0;
        @(posedge clk_sys) disable iff (!rstn)
        adv && ctl_4.phase == nco_pkg::NCO_PM_0 |=>
            phase_addr == $past(phase_acc[31:19]);
    endproperty
    a_phase_0: assert property (p_phase_0) else $error("zero offset phase wrong");

    property p_stall_hold;
        @(posedge clk_sys) disable iff (!rstn)
        !adv |=> $stable(phase_addr) && $stable(rom_data);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("datapath moved during stall");

endmodule : nco_top

// ==== src/nco_pkg.sv ====
// constants, types and the sine table generator for the oscillator
package nco_pkg;

    localparam int NCO_FREQ_W = 32;
    localparam int NCO_SHIFT_W = 64;
    localparam int NCO_PHASE_W = 13;
    localparam int NCO_SINE_W = 12;
    localparam int NCO_QTR_ENTRIES = 2049;

    // pipeline depth from sampling to effect, in main clocks
    localparam int NCO_TRANSFER_STROBE_N_DELAY = 4;
    localparam int NCO_LOAD_DELAY = 5;
    localparam int NCO_ACC_EN_DELAY = 4;
    localparam int NCO_PHASE_DELAY = 4;

    localparam logic [NCO_PHASE_W-1:0] NCO_OFS_0 = 13'h0000;
    localparam logic [NCO_PHASE_W-1:0] NCO_OFS_90 = 13'h0800;
    localparam logic [NCO_PHASE_W-1:0] NCO_OFS_180 = 13'h1000;
    localparam logic [NCO_PHASE_W-1:0] NCO_OFS_270 = 13'h1800;
    localparam logic [NCO_PHASE_W-1:0] NCO_HALF_TURN = 13'h1000;
    localparam logic [NCO_SINE_W-1:0] NCO_MID_LEVEL = 12'h800;
    localparam logic [NCO_SINE_W-1:0] NCO_MIN_LEVEL = 12'h001;

    localparam logic [NCO_SHIFT_W-1:0] NCO_SHIFT_RST = 64'h0000000000000000;
    localparam logic [NCO_FREQ_W-1:0] NCO_FREQ_RST = 32'h00000000;
    localparam logic [NCO_SINE_W-1:0] NCO_SINE_RST = 12'h800;

    typedef enum logic [1:0] {
        NCO_PM_0 = 2'b00,
        NCO_PM_90 = 2'b01,
        NCO_PM_270 = 2'b10,
        NCO_PM_180 = 2'b11
    } nco_pm_type;

    // control inputs sampled together on the main clock
    typedef struct packed {
        logic transfer_strobe_n_n;
        logic load_n;
        logic acc_en_n;
        logic sel_low;
        nco_pm_type phase;
    } nco_ctrl_type;

    localparam nco_ctrl_type NCO_CTRL_RST = '{transfer_strobe_n_n: 1'b1, load_n: 1'b1, acc_en_n: 1'b1,
                                              sel_low: 1'b0, phase: NCO_PM_0};

    // quarter-wave amplitude, round(2047*sin(pi*i/4096)); elaboration time only
    function automatic int nco_sin_q(input int i);
        real x;
        real t;
        real s;
        x = 3.14159265358979323846 * i / 4096.0;
        t = x;
        s = x;
        for (int k = 1; k < 10; k++)
        begin
            t = -t * x * x / ((2.0 * k) * (2.0 * k + 1.0));
            s = s + t;
        end
        return $rtoi(2047.0 * s + 0.5);
    endfunction : nco_sin_q

    function automatic logic [NCO_PHASE_W-1:0] nco_phase_ofs(input nco_pm_type pm);
        case (pm)
            NCO_PM_0: nco_phase_ofs = NCO_OFS_0;
            NCO_PM_90: nco_phase_ofs = NCO_OFS_90;
            NCO_PM_270: nco_phase_ofs = NCO_OFS_270;
            NCO_PM_180: nco_phase_ofs = NCO_OFS_180;
            default: nco_phase_ofs = NCO_OFS_0;
        endcase
    endfunction : nco_phase_ofs

endpackage : nco_pkg

// ==== src/nco_out_buf.sv ====
// two-entry output buffer with valid/ready on both sides
`timescale 1ns/1ps
module nco_out_buf #(
    parameter int W = 12
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);

    logic [W-1:0] tail;
    logic tail_valid;
    logic push;
    logic pop;

    // ready only while the spare slot is free, so a stalled sink loses nothing
    assign in_ready = !tail_valid;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            out_valid <= 1'b0;
            out_data <= nco_pkg::NCO_SINE_RST;
            tail_valid <= 1'b0;
            tail <= nco_pkg::NCO_SINE_RST;
        end
        else if (!out_valid)
        begin
            if (push)
            begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end
        end
        else if (pop)
        begin
            if (tail_valid)
            begin
                out_data <= tail;
                tail_valid <= 1'b0;
            end
            else if (push)
                out_data <= in_data;
            else
                out_valid <= 1'b0;
        end
        else if (push)
        begin
            tail <= in_data;
            tail_valid <= 1'b1;
        end
    end

    property p_hold_stalled;
        @(posedge clk_sys) disable iff (!rstn)
        out_valid && !out_ready |=> out_valid && $stable(out_data);
    endproperty
    a_hold_stalled: assert property (p_hold_stalled) else $error("buffered word changed while stalled");

    property p_no_push_full;
        @(posedge clk_sys) disable iff (!rstn)
        tail_valid && !out_ready |=> tail_valid && !in_ready;
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("full buffer accepted a word");

endmodule : nco_out_buf

// ==== bench/nco_ctrl_model.sv ====
// serial frequency loader standing in for the external controller
`timescale 1ns/1ps
module nco_ctrl_model (
    input wire logic clk_sys,
    output logic shift_clk,
    output logic shift_enable_n,
    output logic shift_msb_first,
    output logic serial_freq_in
);

    initial
    begin
        shift_clk = 1'b0;
        shift_enable_n = 1'b1;
        shift_msb_first = 1'b1;
        serial_freq_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one frame of nbits; gap adds low cycles per bit for a slow controller
    task automatic send(input logic [63:0] v, input int nbits, input logic msb_first, input int gap);
        logic b;
        for (int i = 0; i < nbits; i++)
        begin
            b = msb_first ? v[nbits-1-i] : v[i];
            @(negedge clk_sys);
            shift_clk = 1'b0;
            shift_enable_n = 1'b0;
            shift_msb_first = msb_first;
            serial_freq_in = b;
            repeat (gap) @(negedge clk_sys);
            @(negedge clk_sys);
            shift_clk = 1'b1;
        end
        @(negedge clk_sys);
        shift_clk = 1'b0;
        shift_enable_n = 1'b1;
        // released line shows no stale bit
        serial_freq_in = ~serial_freq_in;
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    // shift clock rises with the enable off; must be ignored
    task automatic noise(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_sys);
            shift_clk = 1'b0;
            serial_freq_in = ~serial_freq_in;
            @(negedge clk_sys);
            shift_clk = 1'b1;
        end
        @(negedge clk_sys);
        shift_clk = 1'b0;
    endtask : noise

endmodule : nco_ctrl_model

// ==== bench/nco_top_bench.sv ====
// self-checking bench for the oscillator: serial load, word select, phase codes, freeze, stall
`timescale 1ns/1ps
module nco_top_bench;
    localparam logic [31:0] W_LO = 32'h20000000;
    localparam logic [31:0] W_HI = 32'h40000000;
    localparam logic [31:0] W_3 = 32'h60000000;

    logic clk_sys;
    logic rstn;
    logic shift_clk;
    logic shift_enable_n;
    logic shift_msb_first;
    logic serial_freq_in;
    logic sel_low_word;
    logic transfer_strobe_n;
    logic load_strobe_n;
    logic accum_enable_n;
    logic [1:0] phase_mod_in;
    logic [nco_pkg::NCO_SINE_W-1:0] sine_out;
    logic out_valid;
    logic out_ready;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int k_run;
    logic [31:0] w_run;
    logic [11:0] hist [int];
    logic [11:0] got [$];

    nco_top i_nco_top (.clk_sys(clk_sys), .rstn(rstn), .shift_clk(shift_clk), .shift_enable_n(shift_enable_n),
        .shift_msb_first(shift_msb_first), .serial_freq_in(serial_freq_in), .sel_low_word(sel_low_word),
        .transfer_strobe_n(transfer_strobe_n), .load_strobe_n(load_strobe_n), .accum_enable_n(accum_enable_n),
        .phase_mod_in(phase_mod_in), .sine_out(sine_out), .out_valid(out_valid), .out_ready(out_ready));

    nco_ctrl_model i_nco_ctrl_model (.clk_sys(clk_sys), .shift_clk(shift_clk), .shift_enable_n(shift_enable_n),
        .shift_msb_first(shift_msb_first), .serial_freq_in(serial_freq_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // history indexed by edge number; accepted samples kept apart
    always @(posedge clk_sys)
    begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
            got.push_back(sine_out);
        #1;
        cyc = cyc + 1;
        hist[cyc] = sine_out;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check12(input string what, input logic [11:0] exp, input logic [11:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %03h seen %03h", what, exp, seen);
        end
    endtask : check12

    task automatic check1(input string what, input logic exp, input logic seen);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0b seen %0b", what, exp, seen);
        end
    endtask : check1

    // symmetric rounding so both half waves match
    function automatic logic [11:0] sine_at(input logic [31:0] acc, input logic [12:0] ofs);
        logic [12:0] p;
        real s;
        int a;
        p = acc[31:19] + ofs;
        s = $sin(2.0 * 3.14159265358979 * p / 8192.0);
        a = $rtoi((s < 0.0 ? -s : s) * 2047.0 + 0.5);
        return (s < 0.0) ? 12'h800 - a[11:0] : 12'h800 + a[11:0];
    endfunction : sine_at

    task automatic wait_to(input int e);
        while (cyc < e)
            @(negedge clk_sys);
    endtask : wait_to

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // accumulator frozen at zero, so each code shows its bare offset
    task automatic test_phase_codes;
        logic [1:0] codes [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
        logic [12:0] ofs [4] = '{13'h0800, 13'h1000, 13'h1800, 13'h0000};
        logic [11:0] prev;
        int k;
        prev = 12'h800;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_sys);
            phase_mod_in = codes[i];
            k = cyc + 1;
            wait_to(k + 6);
            check12("phase before effect", prev, hist[k + 5]);
            prev = sine_at(32'h00000000, ofs[i]);
            check12("phase offset sample", prev, hist[k + 6]);
        end
        $display("phase codes done");
    endtask : test_phase_codes

    task automatic run_word(input logic sel, input logic [31:0] w);
        @(negedge clk_sys);
        sel_low_word = sel;
        transfer_strobe_n = 1'b0;
        load_strobe_n = 1'b0;
        accum_enable_n = 1'b0;
        k_run = cyc + 1;
        w_run = w;
        @(negedge clk_sys);
        transfer_strobe_n = 1'b1;
        load_strobe_n = 1'b1;
        wait_to(k_run + 16);
        for (int i = 1; i <= 8; i++)
            check12("stepped sample", sine_at(w * 32'(i), 13'h0000), hist[k_run + 7 + i]);
        $display("run word %08h sel %0b done", w, sel);
    endtask : run_word

    task automatic test_freeze;
        int k;
        @(negedge clk_sys);
        accum_enable_n = 1'b1;
        k = cyc + 1;
        wait_to(k + 10);
        check12("last step", sine_at(w_run * 32'(k - 2 - k_run), 13'h0000), hist[k + 5]);
        for (int m = k + 6; m <= k + 10; m++)
            check12("frozen sample", sine_at(w_run * 32'(k - 1 - k_run), 13'h0000), hist[m]);
        $display("freeze done");
    endtask : test_freeze

    // quarter-turn steps: a lost or doubled sample breaks the half-turn mirror
    task automatic test_stall;
        logic [11:0] hold;
        @(negedge clk_sys);
        accum_enable_n = 1'b0;
        repeat (10) @(negedge clk_sys);
        got.delete();
        for (int r = 1; r <= 3; r++)
        begin
            repeat (6) @(negedge clk_sys);
            hold = sine_out;
            out_ready = 1'b0;
            repeat (r + 1) @(negedge clk_sys);
            check1("valid while stalled", 1'b1, out_valid);
            check12("held while stalled", hold, sine_out);
            out_ready = 1'b1;
        end
        repeat (12) @(negedge clk_sys);
        check1("enough samples", 1'b1, got.size() > 20);
        for (int i = 0; i + 4 < got.size(); i++)
        begin
            check12("half turn mirror", 12'h000 - got[i], got[i + 2]);
            check12("period", got[i], got[i + 4]);
        end
        $display("stall done");
    endtask : test_stall

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        sel_low_word = 1'b0;
        transfer_strobe_n = 1'b1;
        load_strobe_n = 1'b1;
        accum_enable_n = 1'b1;
        phase_mod_in = 2'b00;
        out_ready = 1'b1;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check12("reset level", 12'h800, sine_out);
        check1("reset valid", 1'b0, out_valid);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        test_phase_codes();
        i_nco_ctrl_model.send({W_HI, W_LO}, 64, 1'b1, 0);
        i_nco_ctrl_model.noise(8);
        run_word(1'b1, W_LO);
        run_word(1'b0, W_HI);
        i_nco_ctrl_model.send({32'h00000000, W_3}, 32, 1'b0, 2);
        run_word(1'b0, W_3);
        run_word(1'b1, W_HI);
        test_freeze();
        test_stall();
        tally_and_finish();
    end

    // whole run is under a thousand clocks
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish();
    end

endmodule : nco_top_bench
